// ===== src/epp_params.svh
// constants for the page-protected two-wire eeprom slave
`ifndef EPP_PARAMS_SVH
`define EPP_PARAMS_SVH

`define EPP_ADDR_W      11
`define EPP_PAGE_W      7
`define EPP_MEM_DEPTH   2048
`define EPP_PAGES       128
`define EPP_PAGE_BYTES  16
`define EPP_BYTE_LAST   4'hf
`define EPP_BIT_LAST    4'h7
`define EPP_BIT_DONE    4'h8
`define EPP_RW_BIT      0
`define EPP_TYPE_HI     7
`define EPP_TYPE_LO     4
`define EPP_UPPER_BIT   6
`define EPP_DEV_TYPE    4'h5
`define EPP_PROT_RD     2'h0
`define EPP_PROT_WR     2'h1
`define EPP_PROT_ER     2'h3
`define EPP_ERASED      8'hff
`define EPP_PROG_MS     10
`define EPP_CLK_NS      4
`define EPP_NS_PER_MS   1000000
`define EPP_STEP_CYC    3
`define EPP_TMR_W       22

`endif

// ===== src/epp_pkg.sv
// types for the page-protected two-wire eeprom slave
package epp_pkg;
    typedef enum logic [5:0] {
        EPP_B_IDLE = 6'h01,
        EPP_B_RX   = 6'h02,
        EPP_B_ACK  = 6'h04,
        EPP_B_TX   = 6'h08,
        EPP_B_MACK = 6'h10,
        EPP_B_IGN  = 6'h20
    } epp_bit_e;

    typedef enum logic [6:0] {
        EPP_P_NONE   = 7'h01,
        EPP_P_CMD    = 7'h02,
        EPP_P_ADDR   = 7'h04,
        EPP_P_WDATA  = 7'h08,
        EPP_P_CTRL   = 7'h10,
        EPP_P_VERIFY = 7'h20,
        EPP_P_READ   = 7'h40
    } epp_phase_e;

    typedef enum logic [4:0] {
        EPP_G_IDLE  = 5'h01,
        EPP_G_ERASE = 5'h02,
        EPP_G_WRITE = 5'h04,
        EPP_G_PROT  = 5'h08,
        EPP_G_WAIT  = 5'h10
    } epp_prog_e;
endpackage

// ===== src/epp_slave.sv
// two-wire eeprom slave with byte/page write, reads and page protection bits
`timescale 1ns/100ps
`include "epp_params.svh"

// Operation
// - write-select holds type, A10..A8, zero b0
// - read-select has b0 one, b3..b1 ignored
// - byte after write-select loads A7..A0
// - each acked write byte advances counter
// - ack write-select low in ninth clock
// - stop erases selected bytes, then writes
// - programming finishes within ten milliseconds
// - one to sixteen data bytes buffered
// - only A3..A0 increment during data entry
// - unaddressed page bytes keep old contents
// - no command ack while programming runs
// - counter ends at last entered byte
// - repeated start aborts write, read follows
// - read byte sent msb first, counter advances
// - read without address uses current counter
// - master ack continues read, wraps to zero
// - protection bit zero suppresses page programming
// - protection bit addressed by page base
// - protect command: address, second write-select, control
// - control b1..b0: 00 read, 01 write, 11 erase
// - protect change needs full sixteen-byte match
// - ack matches, program on stop, counter top
// - protect read msb bit, ack steps pages
// - write-protect pin guards upper memory half
module epp_slave #(
    parameter logic [3:0] DEV_TYPE    = `EPP_DEV_TYPE, // arbitrary value
    parameter int         PROG_CYCLES = (`EPP_PROG_MS * `EPP_NS_PER_MS) / `EPP_CLK_NS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // two-wire bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // write protect pin
    input  wire logic wp_in,
    // status
    output logic      prog_busy
);
    import epp_pkg::*;

    // pin synchronisers and edge history
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [1:0] prev_r;
    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
            prev_r  <= 2'h3;
        end else begin
            sync1_r <= {wp_in, sda_in, scl_in};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r[1:0];
        end
    end

    assign scl_s     = sync2_r[0];
    assign sda_s     = sync2_r[1];
    assign wp_s      = sync2_r[2];
    assign scl_rise  = scl_s & ~prev_r[0];
    assign scl_fall  = ~scl_s & prev_r[0];
    assign start_det = scl_s & prev_r[0] & prev_r[1] & ~sda_s;
    assign stop_det  = scl_s & prev_r[0] & ~prev_r[1] & sda_s;

    // state declarations
    epp_bit_e              bst_r, bst_nxt;
    logic [3:0]            bcnt_r, bcnt_nxt;
    logic [7:0]            shreg_r, shreg_nxt;
    logic                  oe_n_r, oe_n_nxt;
    logic                  mack_r, mack_nxt;
    logic                  push;
    logic                  tx_load;
    logic [7:0]            tx_byte;
    logic                  rd_mode;

    logic [7:0]            fmem_r [2];
    logic [7:0]            fmem_nxt [2];
    logic                  fwp_r, fwp_nxt, frp_r, frp_nxt;
    logic [1:0]            fcnt_r, fcnt_nxt;
    logic                  f_wr_ready;
    logic                  f_rd_valid;
    logic                  f_rd_ready;
    logic                  pop;

    epp_phase_e            ph_r, ph_nxt;
    epp_prog_e             pst_r, pst_nxt;
    logic [`EPP_ADDR_W-1:0] addr_r, addr_nxt, last_r, last_nxt;
    logic                  ack_r, ack_nxt;
    logic                  seen_r, seen_nxt;
    logic                  pwr_r, pwr_nxt, ppr_r, ppr_nxt;
    logic                  pcode_r, pcode_nxt, match_r, match_nxt;
    logic                  prd_r, prd_nxt;
    logic [3:0]            vcnt_r, vcnt_nxt;
    logic [7:0]            pbuf_r [`EPP_PAGE_BYTES];
    logic [7:0]            pbuf_nxt [`EPP_PAGE_BYTES];
    logic [`EPP_PAGE_BYTES-1:0] pval_r, pval_nxt;
    logic [`EPP_TMR_W-1:0] tmr_r, tmr_nxt;
    logic                  erase_en, write_en, prot_we;
    logic [7:0]            rx_byte;
    logic [`EPP_PAGE_W-1:0] page;
    logic                  page_ok;

    logic [7:0]            mem_r [`EPP_MEM_DEPTH];
    logic [`EPP_PAGES-1:0] prot_r;

    // bit engine
    assign rd_mode = (ph_r == EPP_P_READ);

    always_comb begin
        bst_nxt   = bst_r;
        bcnt_nxt  = bcnt_r;
        shreg_nxt = shreg_r;
        oe_n_nxt  = oe_n_r;
        mack_nxt  = mack_r;
        push      = 1'b0;
        tx_load   = 1'b0;
        if (stop_det) begin
            bst_nxt  = EPP_B_IDLE;
            oe_n_nxt = 1'b1;
        end else if (start_det) begin
            bst_nxt  = EPP_B_RX;
            bcnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
        end else begin
            unique case (bst_r)
                EPP_B_IDLE, EPP_B_IGN: begin
                end
                EPP_B_RX: begin
                    if (scl_rise && bcnt_r != `EPP_BIT_DONE) begin
                        shreg_nxt = {shreg_r[6:0], sda_s};
                        bcnt_nxt  = bcnt_r + 4'h1;
                        push      = (bcnt_r == `EPP_BIT_LAST);
                    end else if (scl_fall && bcnt_r == `EPP_BIT_DONE) begin
                        // a byte not yet judged is refused rather than guessed
                        if (fcnt_r == 2'h0 && ack_r) begin
                            bst_nxt  = EPP_B_ACK;
                            oe_n_nxt = 1'b0;
                        end else begin
                            bst_nxt = EPP_B_IGN;
                        end
                    end
                end
                EPP_B_ACK, EPP_B_MACK: begin
                    if (scl_rise && bst_r == EPP_B_MACK) begin
                        mack_nxt = sda_s;
                    end else if (scl_fall) begin
                        bcnt_nxt = 4'h0;
                        oe_n_nxt = 1'b1;
                        if (bst_r == EPP_B_MACK && mack_r) begin
                            bst_nxt = EPP_B_IGN;
                        end else if (rd_mode) begin
                            tx_load   = 1'b1;
                            shreg_nxt = tx_byte;
                            oe_n_nxt  = tx_byte[7];
                            bst_nxt   = EPP_B_TX;
                        end else begin
                            bst_nxt = EPP_B_RX;
                        end
                    end
                end
                EPP_B_TX: begin
                    if (scl_fall) begin
                        if (bcnt_r == `EPP_BIT_LAST) begin
                            bst_nxt  = EPP_B_MACK;
                            oe_n_nxt = 1'b1;
                        end else begin
                            shreg_nxt = {shreg_r[6:0], 1'b0};
                            oe_n_nxt  = shreg_r[6];
                            bcnt_nxt  = bcnt_r + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bst_r   <= EPP_B_IDLE;
            bcnt_r  <= 4'h0;
            shreg_r <= 8'h00;
            oe_n_r  <= 1'b1;
            mack_r  <= 1'b1;
        end else begin
            bst_r   <= bst_nxt;
            bcnt_r  <= bcnt_nxt;
            shreg_r <= shreg_nxt;
            oe_n_r  <= oe_n_nxt;
            mack_r  <= mack_nxt;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = oe_n_r;

    // two-entry receive buffer; the byte handler stalls it during memory steps
    assign f_wr_ready = (fcnt_r != 2'h2);
    assign f_rd_valid = (fcnt_r != 2'h0);
    assign pop        = f_rd_valid & f_rd_ready;
    assign rx_byte    = fmem_r[frp_r];

    always_comb begin
        fmem_nxt = fmem_r;
        fwp_nxt  = fwp_r;
        frp_nxt  = frp_r;
        fcnt_nxt = fcnt_r;
        if (start_det || stop_det) begin
            fcnt_nxt = 2'h0;
            frp_nxt  = fwp_r;
        end else begin
            if (push && f_wr_ready) begin
                fmem_nxt[fwp_r] = shreg_nxt;
                fwp_nxt         = ~fwp_r;
            end
            if (pop) begin
                frp_nxt = ~frp_r;
            end
            fcnt_nxt = fcnt_r + {1'b0, push & f_wr_ready} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fmem_r <= '{default: 8'h00};
            fwp_r  <= 1'b0;
            frp_r  <= 1'b0;
            fcnt_r <= 2'h0;
        end else begin
            fmem_r <= fmem_nxt;
            fwp_r  <= fwp_nxt;
            frp_r  <= frp_nxt;
            fcnt_r <= fcnt_nxt;
        end
    end

    // byte handler and programming sequencer
    assign page       = addr_r[`EPP_ADDR_W-1:4];
    assign page_ok    = prot_r[page] & ~(wp_s & page[`EPP_UPPER_BIT]);
    assign prog_busy  = (pst_r != EPP_G_IDLE);
    assign f_rd_ready = ~(erase_en | write_en | prot_we);
    assign tx_byte    = prd_r ? {prot_r[page], 7'h00} : mem_r[addr_r];

    always_comb begin
        ph_nxt    = ph_r;
        pst_nxt   = pst_r;
        addr_nxt  = addr_r;
        last_nxt  = last_r;
        ack_nxt   = ack_r;
        seen_nxt  = seen_r;
        pwr_nxt   = pwr_r;
        ppr_nxt   = ppr_r;
        pcode_nxt = pcode_r;
        match_nxt = match_r;
        prd_nxt   = prd_r;
        vcnt_nxt  = vcnt_r;
        pbuf_nxt  = pbuf_r;
        pval_nxt  = pval_r;
        tmr_nxt   = tmr_r;
        erase_en  = (pst_r == EPP_G_ERASE);
        write_en  = (pst_r == EPP_G_WRITE);
        prot_we   = (pst_r == EPP_G_PROT);
        unique case (pst_r)
            EPP_G_IDLE: begin
            end
            EPP_G_ERASE: pst_nxt = EPP_G_WRITE;
            EPP_G_WRITE, EPP_G_PROT: begin
                pst_nxt  = EPP_G_WAIT;
                tmr_nxt  = '0;
                addr_nxt = (pst_r == EPP_G_WRITE) ? last_r : {page, `EPP_BYTE_LAST};
            end
            EPP_G_WAIT: begin
                tmr_nxt = tmr_r + 1'b1;
                // the two memory steps count toward the total
                if (tmr_r == `EPP_TMR_W'(PROG_CYCLES - `EPP_STEP_CYC)) begin
                    pst_nxt = EPP_G_IDLE;
                end
            end
        endcase
        if (start_det) begin
            ph_nxt  = EPP_P_CMD;
            pwr_nxt = 1'b0;
            ppr_nxt = 1'b0;
        end else if (stop_det) begin
            ph_nxt   = EPP_P_NONE;
            seen_nxt = 1'b0;
            pwr_nxt  = 1'b0;
            ppr_nxt  = 1'b0;
            if (pwr_r) begin
                pst_nxt = EPP_G_ERASE;
            end else if (ppr_r && match_r) begin
                pst_nxt = EPP_G_PROT;
            end
        end else if (tx_load) begin
            if (prd_r) begin
                addr_nxt = {page + 1'b1, 4'h0};
            end else begin
                addr_nxt = addr_r + 1'b1;
            end
        end else if (pop) begin
            ack_nxt = 1'b0;
            unique case (ph_r)
                EPP_P_CMD: begin
                    if (rx_byte[`EPP_TYPE_HI:`EPP_TYPE_LO] != DEV_TYPE) begin
                        ph_nxt = EPP_P_NONE;
                    end else if (prog_busy) begin
                        ph_nxt = EPP_P_NONE;
                    end else if (rx_byte[`EPP_RW_BIT]) begin
                        ack_nxt = 1'b1;
                        prd_nxt = 1'b0;
                        ph_nxt  = EPP_P_READ;
                    end else if (seen_r) begin
                        ack_nxt = 1'b1;
                        ph_nxt  = EPP_P_CTRL;
                    end else begin
                        ack_nxt  = 1'b1;
                        addr_nxt = {rx_byte[3:1], addr_r[7:0]};
                        ph_nxt   = EPP_P_ADDR;
                    end
                end
                EPP_P_ADDR: begin
                    ack_nxt  = 1'b1;
                    addr_nxt = {addr_r[`EPP_ADDR_W-1:8], rx_byte};
                    seen_nxt = 1'b1;
                    pval_nxt = '0;
                    ph_nxt   = EPP_P_WDATA;
                end
                EPP_P_WDATA: begin
                    ack_nxt                 = 1'b1;
                    pbuf_nxt[addr_r[3:0]]   = rx_byte;
                    pval_nxt[addr_r[3:0]]   = 1'b1;
                    last_nxt                = addr_r;
                    addr_nxt[3:0]           = addr_r[3:0] + 4'h1;
                    pwr_nxt                 = 1'b1;
                end
                EPP_P_CTRL: begin
                    ack_nxt = 1'b1;
                    if (rx_byte[1:0] == `EPP_PROT_RD) begin
                        prd_nxt  = 1'b1;
                        ph_nxt   = EPP_P_READ;
                        addr_nxt = {page, 4'h0};
                    end else if (rx_byte[1:0] == `EPP_PROT_WR || rx_byte[1:0] == `EPP_PROT_ER) begin
                        pcode_nxt = rx_byte[1];
                        vcnt_nxt  = 4'h0;
                        match_nxt = 1'b1;
                        ph_nxt    = EPP_P_VERIFY;
                    end else begin
                        ack_nxt = 1'b0;
                        ph_nxt  = EPP_P_NONE;
                    end
                end
                EPP_P_VERIFY: begin
                    // one byte beyond the page spoils the comparison
                    if (match_r && !ppr_r && rx_byte == mem_r[{page, vcnt_r}]) begin
                        ack_nxt = 1'b1;
                        ppr_nxt = (vcnt_r == `EPP_BYTE_LAST);
                    end else begin
                        match_nxt = 1'b0;
                    end
                    vcnt_nxt = vcnt_r + 4'h1;
                end
                default: ph_nxt = EPP_P_NONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_r    <= EPP_P_NONE;
            pst_r   <= EPP_G_IDLE;
            addr_r  <= '0;
            last_r  <= '0;
            ack_r   <= 1'b0;
            seen_r  <= 1'b0;
            pwr_r   <= 1'b0;
            ppr_r   <= 1'b0;
            pcode_r <= 1'b0;
            match_r <= 1'b0;
            prd_r   <= 1'b0;
            vcnt_r  <= 4'h0;
            pbuf_r  <= '{default: 8'h00};
            pval_r  <= '0;
            tmr_r   <= '0;
        end else begin
            ph_r    <= ph_nxt;
            pst_r   <= pst_nxt;
            addr_r  <= addr_nxt;
            last_r  <= last_nxt;
            ack_r   <= ack_nxt;
            seen_r  <= seen_nxt;
            pwr_r   <= pwr_nxt;
            ppr_r   <= ppr_nxt;
            pcode_r <= pcode_nxt;
            match_r <= match_nxt;
            prd_r   <= prd_nxt;
            vcnt_r  <= vcnt_nxt;
            pbuf_r  <= pbuf_nxt;
            pval_r  <= pval_nxt;
            tmr_r   <= tmr_nxt;
        end
    end

    // cell array: no reset, contents survive like the real array would
    always_ff @(posedge clk) begin
        for (int i = 0; i < `EPP_PAGE_BYTES; i++) begin
            if (pval_r[i] && page_ok) begin
                if (erase_en) begin
                    mem_r[{page, 4'(i)}] <= `EPP_ERASED;
                end else if (write_en) begin
                    mem_r[{page, 4'(i)}] <= pbuf_r[i];
                end
            end
        end
    end

    // protection bits start erased so a fresh part is writable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prot_r <= '1;
        end else if (prot_we) begin
            prot_r[page] <= pcode_r;
        end
    end
endmodule // epp_slave

// ===== tb/epp_slave_asserts.sv
// concurrent checks on the two-wire eeprom slave ports
`timescale 1ns/100ps
module epp_slave_asserts #(
    parameter int PROG_CYCLES = 2500000
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // write protect and status
    input wire logic wp_in,
    input wire logic prog_busy
);
    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;

    // cycles spent busy; cleared whenever the flag drops
    always_comb begin
        busy_cnt_nxt = prog_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_cnt_r <= 32'h0;
        end else begin
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    od_low_a: assert property (sda_out == 1'h0)
        else $error("data pin value not low");
    drive_low_scl_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data drive changed while clock high");
    hold_high_a: assert property (!sda_oe_n && scl_in |=> !sda_oe_n)
        else $error("drive released during clock high");
    busy_quiet_a: assert property (prog_busy |-> sda_oe_n)
        else $error("bus driven while programming");
    start_on_stop_a: assert property ($rose(prog_busy) |-> scl_in && sda_in && $past(scl_in))
        else $error("programming began without a stop");
    busy_len_a: assert property ($fell(prog_busy) |->
        busy_cnt_r >= PROG_CYCLES - 1 && busy_cnt_r <= PROG_CYCLES + 1)
        else $error("programming length wrong");
    busy_max_a: assert property (busy_cnt_r <= PROG_CYCLES + 1)
        else $error("programming overran");
    drive_bound_a: assert property ($fell(sda_oe_n) |-> ##[1:130] sda_oe_n)
        else $error("data line held low too long");
endmodule // epp_slave_asserts

// ===== tb/epp_master.sv
// two-wire bus master model driving the clock and data lines
`timescale 1ns/100ps
module epp_master (
    // clock
    input  wire logic clk,
    // bus lines; clock idles high between frames
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda_w
);
    logic [7:0] rx;
    logic       ack;

    initial begin
        scl = 1'h1;
        sda_m = 1'h1;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // data moves only while the clock is low; sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'h0;
        tk(3);
        sda_m <= b;
        tk(3);
        scl <= 1'h1;
        tk(3);
        r = sda_w;
        tk(3);
    endtask

    task automatic start_c(input logic rep);
        logic r;
        if (rep) begin
            bit_io(1'h1, r);
        end
        sda_m <= 1'h0;
        tk(6);
    endtask

    task automatic stop_c;
        logic r;
        bit_io(1'h0, r);
        sda_m <= 1'h1;
        tk(6);
    endtask

    task automatic put(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'h1, r);
        ack = !r;
    endtask

    // a released ninth bit, then stop, ends a read
    task automatic get(input logic mack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, r);
            rx[i] = r;
        end
        bit_io(!mack, r);
    endtask
endmodule // epp_master

// ===== tb/tb.sv
// self-checking bench for the two-wire eeprom slave
`timescale 1ns/100ps
`include "epp_params.svh"
module tb;
    localparam int         PROG = 200;
    localparam logic [3:0] DEVT = `EPP_DEV_TYPE; // arbitrary value
    logic       clk;
    logic       nrst;
    logic       wp_in;
    logic       scl;
    logic       sda_m;
    logic       sda_out;
    logic       sda_oe_n;
    logic       prog_busy;
    wire logic  sda_w;
    logic [7:0] mem [2048];
    logic       prot [128];
    int         error_cnt = 0;
    int         checks = 0;

    // open drain with pull-up: low when either side pulls
    assign sda_w = sda_m & (sda_oe_n | sda_out);

    epp_master u_mst (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
    epp_slave #(.DEV_TYPE(DEVT), .PROG_CYCLES(PROG)) u_dut (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .wp_in(wp_in), .prog_busy(prog_busy));

    always #2 clk = ~clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic ack_is(input logic e);
        chk({7'h0, u_mst.ack}, {7'h0, e});
    endtask

    function automatic logic [7:0] pat(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h0b};
    endfunction

    task automatic wait_idle;
        int n = 0;
        while (prog_busy !== 1'h0 && n < PROG + 8) begin
            @(posedge clk);
            n++;
        end
        chk({7'h0, prog_busy}, 8'h00);
    endtask

    task automatic adr(input logic [10:0] a);
        u_mst.start_c(1'h0);
        u_mst.put({DEVT, a[10:8], 1'h0});
        ack_is(1'h1);
        u_mst.put(a[7:0]);
        ack_is(1'h1);
    endtask

    task automatic wr(input logic [10:0] a, input int n, input logic [7:0] x, input logic poll);
        logic [10:0] b;
        adr(a);
        for (int i = 0; i < n; i++) begin
            b = {a[10:4], a[3:0] + i[3:0]};
            u_mst.put(pat(b) ^ x);
            ack_is(1'h1);
            if (prot[a[10:4]] && !(wp_in && a[10])) begin
                mem[b] = pat(b) ^ x;
            end
        end
        u_mst.stop_c;
        if (poll) begin
            chk({7'h0, prog_busy}, 8'h01);
            u_mst.start_c(1'h0);
            u_mst.put({DEVT, a[10:8], 1'h0});
            ack_is(1'h0);
            u_mst.stop_c;
        end
        wait_idle;
    endtask

    task automatic rd(input logic [10:0] a, input logic rnd, input int n);
        if (rnd) begin
            adr(a);
        end
        u_mst.start_c(rnd);
        u_mst.put({DEVT, ~a[10:8], 1'h1});
        ack_is(1'h1);
        for (int i = 0; i < n; i++) begin
            u_mst.get(i < n - 1);
            chk(u_mst.rx, mem[a + i[10:0]]);
        end
        u_mst.stop_c;
    endtask

    task automatic pre(input logic [10:0] a, input logic [7:0] ctl);
        adr(a);
        u_mst.start_c(1'h1);
        u_mst.put({DEVT, a[10:8], 1'h0});
        ack_is(1'h1);
        u_mst.put(ctl);
        ack_is(1'h1);
    endtask

    task automatic pcmd(input logic [10:0] a, input logic [1:0] op, input int bad);
        pre(a, {6'h2a, op});
        for (int i = 0; i < 16; i++) begin
            u_mst.put(mem[a + i[10:0]] ^ {7'h0, i == bad});
            ack_is(i < bad);
        end
        u_mst.stop_c;
        if (bad > 15) begin
            prot[a[10:4]] = op[1];
        end
        wait_idle;
    endtask

    task automatic prd(input logic [10:0] a, input int n);
        pre(a, {6'h15, `EPP_PROT_RD});
        for (int i = 0; i < n; i++) begin
            u_mst.get(i < n - 1);
            chk({u_mst.rx[7], 7'h0}, {prot[a[10:4] + i[6:0]], 7'h0});
        end
        u_mst.stop_c;
    endtask

    task automatic t_fill;
        wr(11'h7f0, 16, 8'h00, 1'h1);
        wr(11'h000, 16, 8'h00, 1'h1);
        rd(11'h7fe, 1'h1, 4);
    endtask

    task automatic t_part;
        wr(11'h00e, 3, 8'hff, 1'h1);
        rd(11'h000, 1'h0, 2);
        rd(11'h00e, 1'h1, 2);
    endtask

    task automatic t_prot;
        pcmd(11'h7f0, `EPP_PROT_WR, 3);
        prd(11'h7f0, 2);
        pcmd(11'h7f0, `EPP_PROT_WR, 16);
        rd(11'h7ff, 1'h0, 2);
        prd(11'h7f0, 2);
        wr(11'h7f2, 2, 8'h3c, 1'h0);
        rd(11'h7f2, 1'h1, 2);
        pcmd(11'h7f0, `EPP_PROT_ER, 16);
        prd(11'h7f0, 1);
        wr(11'h7f2, 1, 8'hc3, 1'h1);
        rd(11'h7f2, 1'h1, 1);
    endtask

    task automatic t_wp;
        wp_in <= 1'h1;
        wr(11'h7f5, 1, 8'h11, 1'h0);
        wr(11'h005, 1, 8'h22, 1'h1);
        rd(11'h7f5, 1'h1, 1);
        rd(11'h005, 1'h1, 1);
        wp_in <= 1'h0;
    endtask

    task automatic t_foreign;
        u_mst.start_c(1'h0);
        u_mst.put({DEVT ^ 4'hf, 4'h0});
        ack_is(1'h0);
        u_mst.put(8'h00);
        ack_is(1'h0);
        u_mst.stop_c;
        wait_idle;
    endtask

    // pending data dropped by a repeated start; reserved control code refused
    task automatic t_abort;
        adr(11'h003);
        u_mst.put(8'h5a);
        ack_is(1'h1);
        u_mst.start_c(1'h1);
        u_mst.put({DEVT, 3'h0, 1'h1});
        ack_is(1'h1);
        u_mst.get(1'h0);
        chk(u_mst.rx, mem[11'h004]);
        u_mst.stop_c;
        chk({7'h0, prog_busy}, 8'h00);
        rd(11'h003, 1'h1, 1);
        adr(11'h7f0);
        u_mst.start_c(1'h1);
        u_mst.put({DEVT, 3'h7, 1'h0});
        ack_is(1'h1);
        u_mst.put(8'h02);
        ack_is(1'h0);
        u_mst.stop_c;
        chk({7'h0, prog_busy}, 8'h00);
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        nrst = 1'h0;
        wp_in = 1'h0;
        foreach (prot[i]) prot[i] = 1'h1;
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        repeat (4) @(posedge clk);
        t_fill;
        t_part;
        t_prot;
        t_wp;
        t_foreign;
        t_abort;
        close_out;
    end

    // run needs roughly 22k cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        close_out;
    end
endmodule // tb

bind epp_slave epp_slave_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk(clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wp_in(wp_in), .prog_busy(prog_busy));
